// [core/pmv_pkg.sv]
/*
 pmv_pkg: constants, state codes and word-packing helpers for the per-phase
 absolute-mean and voltage rms block. Assumes an 8 kHz sample rate and a
 200 MHz system clock.
*/
package pmv_pkg;
   // widths of samples, results and held offsets
   localparam int SMP_W     = 24;
   localparam int MAV_W     = 20;
   localparam int RMS_W     = 24;
   localparam int OFS_W     = 28;
   localparam int WORD_W    = 32;
   localparam int N_PH      = 3;
   localparam int RAD_W     = 50;
   localparam int ROOT_W    = 25;
   // absolute-mean scaling: gain / 2^shift brings full scale near 209,686
   localparam int MAV_GAIN       = 3641;
   localparam int MAV_GAIN_SHIFT = 16;
   // offset term weight is 2^7 = 128
   localparam int OFS_SCALE_SHIFT = 7;
   // low-ripple averaging window
   localparam int SAMPLE_RATE_HZ = 8000;
   localparam int LRIP_PERIOD_MS = 1024;
   localparam int LRIP_SAMPLES   = LRIP_PERIOD_MS * SAMPLE_RATE_HZ / 1000;
   localparam int LRIP_LOG2      = $clog2(LRIP_SAMPLES);
   // wiring selection code for three-wire delta
   localparam logic [1:0] WIRING_DELTA = 2'h1;
   localparam logic [RMS_W-1:0] RMS_SAT = 24'h7FFFFF;

   typedef enum logic [3:0] {
      PMV_IDLE  = 4'h1,
      PMV_CALC  = 4'h2,
      PMV_ROOT  = 4'h4,
      PMV_STORE = 4'h8
   } pmv_state_t;

   // 20-bit unsigned value as a 32-bit word, upper twelve bits zero
   function automatic logic [WORD_W-1:0] pmv_word_u20(input logic [MAV_W-1:0] v);
      pmv_word_u20 = {{(WORD_W-MAV_W){1'b0}}, v};
   endfunction : pmv_word_u20

   // 24-bit value as a 32-bit word, upper eight bits zero
   function automatic logic [WORD_W-1:0] pmv_word_s24(input logic [RMS_W-1:0] v);
      pmv_word_s24 = {{(WORD_W-RMS_W){1'b0}}, v};
   endfunction : pmv_word_s24
endpackage : pmv_pkg

// [core/pmv_isqrt.sv]
/*
 pmv_isqrt: iterative integer square root, two radicand bits per clock.
 Assumes start is a one-cycle pulse given only while busy is low.
*/
`timescale 1ns/10ps
`default_nettype none
module pmv_isqrt
   import pmv_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              start,
   input  wire logic [RAD_W-1:0]  radicand,
   output logic                   busy,
   output logic                   done,
   output logic [ROOT_W-1:0]      root
);
   logic [RAD_W-1:0]   rad_r;
   logic [ROOT_W+1:0]  rem_r;
   logic [ROOT_W-1:0]  root_r;
   logic [4:0]         cnt_r;
   logic               busy_r;
   logic               done_r;
   logic [ROOT_W+1:0]  rem_sh;
   logic [ROOT_W+1:0]  trial;

   // one result bit per step: compare shifted remainder with 4*root+1
   always_comb begin
      rem_sh = {rem_r[ROOT_W-1:0], rad_r[RAD_W-1 -: 2]};
      trial  = {root_r, 2'h1};
   end

   // step counter and datapath
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rad_r  <= '0;
         rem_r  <= '0;
         root_r <= '0;
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start && !busy_r) begin
            rad_r  <= radicand;
            rem_r  <= '0;
            root_r <= '0;
            cnt_r  <= 5'(ROOT_W - 1);
            busy_r <= 1'b1;
         end else if (busy_r) begin
            rad_r <= {rad_r[RAD_W-3:0], 2'h0};
            if (rem_sh >= trial) begin
               rem_r  <= rem_sh - trial;
               root_r <= {root_r[ROOT_W-2:0], 1'b1};
            end else begin
               rem_r  <= rem_sh;
               root_r <= {root_r[ROOT_W-2:0], 1'b0};
            end
            if (cnt_r == '0) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
            cnt_r <= cnt_r - 5'h1;
         end
      end
   end

   assign busy = busy_r;
   assign done = done_r;
   assign root = root_r;
endmodule : pmv_isqrt
`default_nettype wire

// [core/pmv_top.sv]
/*
 pmv_top: per-phase current absolute-mean estimate, voltage rms with
 offset term, 1.024 s low-ripple voltage rms, and delta line voltage.
 Assumes sample_valid pulses at 8 kHz from logic on clk, with the six
 sample buses valid in that cycle; offset writes come from the serial
 port logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
// How it works
// RULE1: current high-pass, absolute value, then low-pass
// RULE2: unsigned 20-bit estimate per phase, 8 kHz
// RULE3: estimate only for three phase currents
// RULE4: estimate runs in both power modes
// RULE5: full-scale sine gives about 209,686 / 210,921
// RULE6: estimate read as 32 bits, top twelve zero
// RULE7: estimate settles within 0.5% in 500 ms
// RULE8: host applies its own gain and offset
// RULE9: signed 24-bit voltage rms per phase, 8 kHz
// RULE10: full-scale sine gives 0x3FF6A6
// RULE11: host reads rms at zero crossings
// RULE12: voltage rms settles within 440 ms
// RULE13: voltage rms read as 32 bits, top eight zero
// RULE14: smooth rms is mean of 8192 samples
// RULE15: smooth rms within 99% after 2.048 s
// RULE16: add 128 times offset before root
// RULE17: offset held sign-extended to 28 bits
// RULE18: host calibrates offset at small non-zero voltage
// RULE19: delta wiring zeroes phase B powers
// RULE20: delta puts A-to-C rms in phase B
// RULE21: negative root input clamps to zero
module pmv_top
   import pmv_pkg::*;
#(
   parameter int HPF_SHIFT = 10,
   parameter int MAV_SHIFT = 9,
   parameter int RMS_SHIFT = 9
) (
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   input  wire logic                        sample_valid,
   input  wire logic signed [SMP_W-1:0]     current_a,
   input  wire logic signed [SMP_W-1:0]     current_b,
   input  wire logic signed [SMP_W-1:0]     current_c,
   input  wire logic signed [SMP_W-1:0]     voltage_a,
   input  wire logic signed [SMP_W-1:0]     voltage_b,
   input  wire logic signed [SMP_W-1:0]     voltage_c,
   input  wire logic                        full_power_mode,
   input  wire logic                        reduced_power_mode,
   input  wire logic [1:0]                  wiring_config_select,
   input  wire logic                        offset_wr_en,
   input  wire logic [1:0]                  offset_wr_sel,
   input  wire logic [pmv_pkg::WORD_W-1:0]  offset_wr_data,
   output logic [pmv_pkg::WORD_W-1:0]       phase_a_current_absmean,
   output logic [pmv_pkg::WORD_W-1:0]       phase_b_current_absmean,
   output logic [pmv_pkg::WORD_W-1:0]       phase_c_current_absmean,
   output logic [pmv_pkg::WORD_W-1:0]       phase_a_voltage_rms,
   output logic [pmv_pkg::WORD_W-1:0]       phase_b_voltage_rms,
   output logic [pmv_pkg::WORD_W-1:0]       phase_c_voltage_rms,
   output logic [pmv_pkg::RMS_W-1:0]        phase_a_voltage_rms_smooth,
   output logic [pmv_pkg::RMS_W-1:0]        phase_b_voltage_rms_smooth,
   output logic [pmv_pkg::RMS_W-1:0]        phase_c_voltage_rms_smooth,
   output logic [pmv_pkg::WORD_W-1:0]       phase_a_voltage_rms_offset,
   output logic [pmv_pkg::WORD_W-1:0]       phase_b_voltage_rms_offset,
   output logic [pmv_pkg::WORD_W-1:0]       phase_c_voltage_rms_offset,
   output logic                             phase_b_power_zero,
   output logic                             update_done
);
   localparam int DC_W   = SMP_W + HPF_SHIFT + 1;
   localparam int SCL_W  = MAV_W + 1;
   localparam int MAVA_W = SCL_W + MAV_SHIFT + 1;
   localparam int MSQA_W = RAD_W + RMS_SHIFT + 1;
   localparam int COR_W  = RAD_W + 2;
   localparam int LACC_W = RMS_W + LRIP_LOG2;

   // shifts past these bounds overflow the accumulator widths chosen above
   if (HPF_SHIFT < 1 || HPF_SHIFT > 16 || MAV_SHIFT < 1 || MAV_SHIFT > 16 ||
       RMS_SHIFT < 1 || RMS_SHIFT > 16) begin : g_bad_shift
      $error("pmv_top: filter shift out of range 1..16");
   end

   pmv_state_t                 st_r;
   logic [1:0]                 ch_r;
   logic signed [SMP_W-1:0]    iin_r [N_PH];
   logic signed [SMP_W-1:0]    vin_r [N_PH];
   logic signed [DC_W-1:0]     dc_r [N_PH];
   logic [MAVA_W-1:0]          mava_r [N_PH];
   logic [MSQA_W-1:0]          msqa_r [N_PH];
   logic [MAV_W-1:0]           mav_r [N_PH];
   logic [RMS_W-1:0]           rms_r [N_PH];
   logic [RMS_W-1:0]           smooth_r [N_PH];
   logic signed [OFS_W-1:0]    ofs_r [N_PH];
   logic [LACC_W-1:0]          lacc_r [N_PH];
   logic [LRIP_LOG2-1:0]       lcnt_r;
   logic                       delta_r;
   logic                       upd_r;
   logic                       root_start;
   logic                       root_busy;
   logic                       root_done;
   logic [ROOT_W-1:0]          root_val;
   logic [RAD_W-1:0]           rad_nxt;
   logic [RAD_W-1:0]           rad_r;
   logic signed [SMP_W:0]      hp;
   logic [SMP_W:0]             ab;
   logic [SCL_W-1:0]           scl;
   logic [MAVA_W-1:0]          mava_nxt;
   logic signed [SMP_W:0]      vsel;
   logic [RAD_W-1:0]           sq;
   logic [MSQA_W-1:0]          msqa_nxt;
   logic signed [COR_W-1:0]    corr;
   logic [RMS_W-1:0]           rms_sat;
   logic [LACC_W-1:0]          lacc_sum;

   // per-channel arithmetic, shared by all three phases in turn
   always_comb begin
      // RULE1 dc removal, rectify
      hp  = (SMP_W+1)'(iin_r[ch_r]) - (SMP_W+1)'(dc_r[ch_r] >>> HPF_SHIFT);
      ab  = hp[SMP_W] ? (SMP_W+1)'(-hp) : (SMP_W+1)'(hp);
      // RULE5 gain trims full-scale sine to documented count
      scl = SCL_W'((37'(ab) * 37'(MAV_GAIN)) >> MAV_GAIN_SHIFT);
      // RULE7 one-pole smoothing of rectified current
      mava_nxt = mava_r[ch_r] + MAVA_W'(scl) - (mava_r[ch_r] >> MAV_SHIFT);
      // RULE20 delta wiring feeds A-to-C line voltage to phase B
      if (ch_r == 2'h1 && delta_r)
         vsel = (SMP_W+1)'(vin_r[0]) - (SMP_W+1)'(vin_r[2]);
      else
         vsel = (SMP_W+1)'(vin_r[ch_r]);
      // widen before squaring; a bare product would keep only 25 bits
      sq = unsigned'(RAD_W'(vsel) * RAD_W'(vsel));
      // RULE12 mean-square low-pass sets the settling time
      msqa_nxt = msqa_r[ch_r] + MSQA_W'(sq) - (msqa_r[ch_r] >> RMS_SHIFT);
      // RULE16 offset weighted by 128 joins the mean square
      corr = $signed({2'h0, RAD_W'(msqa_nxt >> RMS_SHIFT)}) +
             ($signed(COR_W'(ofs_r[ch_r])) <<< OFS_SCALE_SHIFT);
      // RULE21 negative sum would give a bogus root
      rad_nxt = corr[COR_W-1] ? '0 : RAD_W'(corr);
      // RULE10 root of mean square of full-scale sine is 0x3FF6A6
      rms_sat = (root_val[ROOT_W-1:RMS_W-1] != '0) ? RMS_SAT : RMS_W'(root_val);
      lacc_sum = lacc_r[ch_r] + LACC_W'(rms_sat);
   end

   // sequencer: one sample set walks the three phases in turn
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= PMV_IDLE;
         ch_r <= 2'h0;
      end else begin
         unique case (st_r)
            PMV_IDLE: begin
               if (sample_valid) begin
                  st_r <= PMV_CALC;
                  ch_r <= 2'h0;
               end
            end
            PMV_CALC: st_r <= PMV_ROOT;
            PMV_ROOT: begin
               if (root_done)
                  st_r <= PMV_STORE;
            end
            PMV_STORE: begin
               if (ch_r == 2'h2) begin
                  st_r <= PMV_IDLE;
               end else begin
                  st_r <= PMV_CALC;
                  ch_r <= ch_r + 2'h1;
               end
            end
         endcase
      end
   end

   // sample capture; samples arriving mid-walk are dropped, 8 kHz leaves room
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int k = 0; k < N_PH; k++) begin
            iin_r[k] <= '0;
            vin_r[k] <= '0;
         end
      end else if (st_r == PMV_IDLE && sample_valid) begin
         iin_r[0] <= current_a;
         iin_r[1] <= current_b;
         iin_r[2] <= current_c;
         vin_r[0] <= voltage_a;
         vin_r[1] <= voltage_b;
         vin_r[2] <= voltage_c;
      end
   end

   // filter state, absolute-mean results
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int k = 0; k < N_PH; k++) begin
            dc_r[k]   <= '0;
            mava_r[k] <= '0;
            msqa_r[k] <= '0;
            mav_r[k]  <= '0;
         end
      end else if (st_r == PMV_CALC) begin
         // RULE4 current path ignores the power mode
         // RULE3 only the three phase currents have this path
         dc_r[ch_r]   <= dc_r[ch_r] + DC_W'(hp);
         mava_r[ch_r] <= mava_nxt;
         // RULE2 clamp to unsigned 20 bits
         mav_r[ch_r]  <= (mava_nxt >> MAV_SHIFT) > MAVA_W'({MAV_W{1'b1}}) ?
                         {MAV_W{1'b1}} : MAV_W'(mava_nxt >> MAV_SHIFT);
         if (full_power_mode && !reduced_power_mode)
            msqa_r[ch_r] <= msqa_nxt;
      end
   end

   // root input register and start pulse
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         rad_r <= '0;
      else if (st_r == PMV_CALC)
         rad_r <= rad_nxt;
   end
   assign root_start = (st_r == PMV_ROOT) && !root_busy && !root_done;

   pmv_isqrt u_root (
      .clk      (clk),
      .reset_n  (reset_n),
      .start    (root_start),
      .radicand (rad_r),
      .busy     (root_busy),
      .done     (root_done),
      .root     (root_val)
   );

   // rms results and low-ripple averaging; rms held in reduced power mode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int k = 0; k < N_PH; k++) begin
            rms_r[k]    <= '0;
            smooth_r[k] <= '0;
            lacc_r[k]   <= '0;
         end
      end else if (st_r == PMV_STORE && full_power_mode && !reduced_power_mode) begin
         // RULE9 signed 24-bit result, never above the positive max
         rms_r[ch_r] <= rms_sat;
         // RULE14 window of 8192 sample sets, then reload
         if (lcnt_r == LRIP_LOG2'(LRIP_SAMPLES - 1)) begin
            smooth_r[ch_r] <= RMS_W'(lacc_sum >> LRIP_LOG2);
            lacc_r[ch_r]   <= '0;
         end else begin
            lacc_r[ch_r] <= lacc_sum;
         end
      end
   end

   // RULE15 window count, one per sample set completed in full power mode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         lcnt_r <= '0;
      else if (st_r == PMV_STORE && ch_r == 2'h2 && full_power_mode && !reduced_power_mode)
         lcnt_r <= lcnt_r + LRIP_LOG2'(1);
   end

   // offset registers, written from the serial port logic
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int k = 0; k < N_PH; k++)
            ofs_r[k] <= '0;
      end else if (offset_wr_en && offset_wr_sel != 2'h3) begin
         // RULE17 keep 24 bits, sign-extend to 28
         ofs_r[offset_wr_sel] <= OFS_W'($signed(offset_wr_data[RMS_W-1:0]));
      end
   end

   // wiring flag and update pulse, registered
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         delta_r <= 1'b0;
         upd_r   <= 1'b0;
      end else begin
         // RULE19 delta wiring: phase B carries no power
         delta_r <= (wiring_config_select == WIRING_DELTA);
         upd_r   <= (st_r == PMV_STORE) && (ch_r == 2'h2);
      end
   end

   // register words as the serial port returns them
   // RULE6 twelve zero bits above the estimate
   assign phase_a_current_absmean = pmv_word_u20(mav_r[0]);
   assign phase_b_current_absmean = pmv_word_u20(mav_r[1]);
   assign phase_c_current_absmean = pmv_word_u20(mav_r[2]);
   // RULE13 eight zero bits above the rms
   assign phase_a_voltage_rms     = pmv_word_s24(rms_r[0]);
   assign phase_b_voltage_rms     = pmv_word_s24(rms_r[1]);
   assign phase_c_voltage_rms     = pmv_word_s24(rms_r[2]);
   assign phase_a_voltage_rms_smooth = smooth_r[0];
   assign phase_b_voltage_rms_smooth = smooth_r[1];
   assign phase_c_voltage_rms_smooth = smooth_r[2];
   assign phase_a_voltage_rms_offset = {4'h0, ofs_r[0]};
   assign phase_b_voltage_rms_offset = {4'h0, ofs_r[1]};
   assign phase_c_voltage_rms_offset = {4'h0, ofs_r[2]};
   assign phase_b_power_zero = delta_r;
   assign update_done        = upd_r;

   // checks
   sequence s_walk_start;
      st_r == PMV_IDLE && sample_valid;
   endsequence
   sequence s_walk_end;
      ##[60:120] (st_r == PMV_STORE && ch_r == 2'h2);
   endsequence
   property p_walk;
      @(posedge clk) disable iff (!reset_n) s_walk_start |-> s_walk_end;
   endproperty
   a_walk: assert property (p_walk) else $error("sample set not finished in time"); // RULE2
   property p_root_time;
      @(posedge clk) disable iff (!reset_n) root_start |-> ##[25:27] root_done;
   endproperty
   a_root_time: assert property (p_root_time) else $error("root took wrong time"); // RULE9
   property p_mav_pad;
      @(posedge clk) disable iff (!reset_n) phase_b_current_absmean[31:20] == 12'h000;
   endproperty
   a_mav_pad: assert property (p_mav_pad) else $error("estimate word top not zero"); // RULE6
   property p_rms_pos;
      @(posedge clk) disable iff (!reset_n)
         phase_c_voltage_rms[31:23] == 9'h000;
   endproperty
   a_rms_pos: assert property (p_rms_pos) else $error("rms word negative or top set"); // RULE9
   property p_smooth_hold;
      @(posedge clk) disable iff (!reset_n)
         !$stable(phase_a_voltage_rms_smooth) |-> $past(lcnt_r) == LRIP_LOG2'(LRIP_SAMPLES - 1);
   endproperty
   a_smooth_hold: assert property (p_smooth_hold) else $error("smooth moved mid-window"); // RULE14
   property p_delta;
      @(posedge clk) disable iff (!reset_n)
         wiring_config_select == WIRING_DELTA |=> phase_b_power_zero;
   endproperty
   a_delta: assert property (p_delta) else $error("phase B power not zeroed"); // RULE19
   property p_ofs_ext;
      @(posedge clk) disable iff (!reset_n)
         offset_wr_en && offset_wr_sel == 2'h1 |=>
            phase_b_voltage_rms_offset[31:23] == {4'h0, {5{$past(offset_wr_data[23])}}};
   endproperty
   a_ofs_ext: assert property (p_ofs_ext) else $error("offset not sign-extended"); // RULE17
   property p_clamp;
      @(posedge clk) disable iff (!reset_n)
         st_r == PMV_CALC && corr[COR_W-1] |=> rad_r == '0;
   endproperty
   a_clamp: assert property (p_clamp) else $error("negative root input not clamped"); // RULE21
   logic [MAV_W-1:0] mav_nxt_view;
   assign mav_nxt_view = (mava_nxt >> MAV_SHIFT) > MAVA_W'({MAV_W{1'b1}}) ?
                         {MAV_W{1'b1}} : MAV_W'(mava_nxt >> MAV_SHIFT);
   property p_mav_rate;
      @(posedge clk) disable iff (!reset_n)
         s_walk_start ##1 (st_r == PMV_CALC && ch_r == 2'h0) |=> mav_r[0] == $past(mav_nxt_view);
   endproperty
   a_mav_rate: assert property (p_mav_rate) else $error("estimate not refreshed"); // RULE4
endmodule : pmv_top
`default_nettype wire

// [verif/pmv_sample_model.sv]
/*
 pmv_sample_model: stands in for the converters feeding the six sample buses.
 Assumes send is a one-cycle request, given only once the block has finished.
*/
`timescale 1ns/10ps
`default_nettype none
module pmv_sample_model (
   input  wire logic                             clk,
   input  wire logic                             reset_n,
   input  wire logic                             send,
   input  wire logic [5:0][pmv_pkg::SMP_W-1:0]   amp,
   output logic                                  sample_valid,
   output logic [5:0][pmv_pkg::SMP_W-1:0]        smp
);
   import pmv_pkg::*;
   logic neg_r;

   // sign flips every set: squares and absolute values stay constant, dc stays zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sample_valid <= 1'b0;
         neg_r        <= 1'b0;
         smp          <= '0;
      end else if (send) begin
         sample_valid <= 1'b1;
         neg_r        <= ~neg_r;
         for (int k = 0; k < 6; k++) begin
            smp[k] <= neg_r ? -amp[k] : amp[k];
         end
      end else begin
         sample_valid <= 1'b0;
         // released buses toggle, so a stale copy is never mistaken for data
         smp <= ~smp;
      end
   end
endmodule : pmv_sample_model
`default_nettype wire

// [verif/testbench.sv]
/*
 testbench: drives sample sets and offset writes into pmv_top, checks results.
 Assumes pmv_pkg and pmv_sample_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import pmv_pkg::*;
   logic                   clk, reset_n, send, sample_valid, update_done, pbz;
   logic                   full_power_mode, reduced_power_mode, offset_wr_en;
   logic [1:0]             wiring, offset_wr_sel;
   logic [31:0]            offset_wr_data;
   logic [5:0][SMP_W-1:0]  amp, smp;
   logic [2:0][31:0]       mav_o, rms_o, ofs_o;
   logic [2:0][23:0]       ofs, vexp, smo;
   int                     n_errors, n_tests, seed;

   // short absolute-mean and rms filter shifts so settling takes tens of sets, not thousands; high-pass keeps 10
   pmv_top #(.HPF_SHIFT(10), .MAV_SHIFT(2), .RMS_SHIFT(2)) dut_u (
      .clk(clk), .reset_n(reset_n), .sample_valid(sample_valid),
      .current_a(smp[0]), .current_b(smp[1]), .current_c(smp[2]),
      .voltage_a(smp[3]), .voltage_b(smp[4]), .voltage_c(smp[5]),
      .full_power_mode(full_power_mode), .reduced_power_mode(reduced_power_mode),
      .wiring_config_select(wiring), .offset_wr_en(offset_wr_en),
      .offset_wr_sel(offset_wr_sel), .offset_wr_data(offset_wr_data),
      .phase_a_current_absmean(mav_o[0]), .phase_b_current_absmean(mav_o[1]),
      .phase_c_current_absmean(mav_o[2]), .phase_a_voltage_rms(rms_o[0]),
      .phase_b_voltage_rms(rms_o[1]), .phase_c_voltage_rms(rms_o[2]),
      .phase_a_voltage_rms_smooth(smo[0]), .phase_b_voltage_rms_smooth(smo[1]),
      .phase_c_voltage_rms_smooth(smo[2]), .phase_a_voltage_rms_offset(ofs_o[0]),
      .phase_b_voltage_rms_offset(ofs_o[1]), .phase_c_voltage_rms_offset(ofs_o[2]),
      .phase_b_power_zero(pbz), .update_done(update_done));

   pmv_sample_model src_u (.clk(clk), .reset_n(reset_n), .send(send), .amp(amp),
      .sample_valid(sample_valid), .smp(smp));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic give_verdict();
      if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   // exact compare when tol is zero, else a window around the expectation
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp, int tol = 0);
      n_tests++;
      if ((^seen === 1'bx) || (tol == 0 ? seen !== exp :
          (seen > exp ? seen - exp : exp - seen) > tol)) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   function automatic logic [31:0] exp_mav(logic [23:0] a);
      return 32'((longint'(a) * MAV_GAIN) >>> MAV_GAIN_SHIFT);
   endfunction : exp_mav

   function automatic logic [31:0] exp_rms(logic [23:0] v, logic [23:0] os);
      real r;
      r = real'(v) * real'(v) + 128.0 * real'($signed(os));
      if (r <= 0.0) return 32'h0;
      return 32'($rtoi($floor($sqrt(r))));
   endfunction : exp_rms

   // upper data bits carry junk that must be ignored
   task automatic wr_ofs(logic [1:0] s, logic [23:0] d);
      offset_wr_en   <= 1'b1;
      offset_wr_sel  <= s;
      offset_wr_data <= {8'hA5, d};
      @(posedge clk);
      offset_wr_en   <= 1'b0;
      if (s != 2'h3) ofs[s] = d;
      @(posedge clk);
   endtask : wr_ofs

   // one set per request, next only after the block reports completion
   task automatic run_sets(int n);
      int w;
      for (int i = 0; i < n; i++) begin
         send <= 1'b1;
         @(posedge clk);
         send <= 1'b0;
         w = 0;
         while (update_done !== 1'b1 && w < 300) begin
            @(posedge clk);
            w++;
         end
         if (w >= 300) begin
            n_errors++;
            give_verdict();
         end
         repeat (4) @(posedge clk);
      end
   endtask : run_sets

   task automatic check_all();
      logic [23:0] va;
      logic [31:0] e;
      // read between sets, as a host would at a crossing
      for (int k = 0; k < 3; k++) begin
         // raw reading; the host trims gain and offset itself
         chk("absmean", mav_o[k], exp_mav(amp[k]), exp_mav(amp[k]) / 50 + 8);
         chk("absmean_top", 32'(mav_o[k][31:20]), 32'h0);
         va = vexp[k];
         if (k == 1 && wiring == 2'h1)
            va = (vexp[0] > vexp[2]) ? vexp[0] - vexp[2] : vexp[2] - vexp[0];
         e = exp_rms(va, ofs[k]);
         chk("voltage_rms", rms_o[k], e, e / 50 + 8);
         // far fewer than 8192 sets here, no window has closed
         chk("voltage_rms_smooth", 32'(smo[k]), 32'h0);
         chk("voltage_rms_top", 32'(rms_o[k][31:23]), 32'h0);
         chk("offset_word", ofs_o[k], {4'h0, {4{ofs[k][23]}}, ofs[k]});
      end
      chk("b_power_zero", 32'(pbz), 32'(wiring == 2'h1));
   endtask : check_all

   initial begin
      logic [5:0][23:0] a;
      logic [23:0]      o;
      seed = 42;
      n_errors = 0;
      n_tests = 0;
      reset_n = 1'b0;
      send = 1'b0;
      full_power_mode = 1'b1;
      reduced_power_mode = 1'b0;
      wiring = 2'h0;
      offset_wr_en = 1'b0;
      offset_wr_sel = 2'h0;
      offset_wr_data = 32'h0;
      amp = '0;
      ofs = '0;
      vexp = '0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      for (int k = 0; k < 3; k++) begin
         chk("reset_absmean", mav_o[k], 32'h0);
         chk("reset_rms", rms_o[k], 32'h0);
      end
      // corner sets first: zero, full scale, clamp, small calibration level
      for (int it = 0; it < 8; it++) begin
         for (int k = 0; k < 6; k++) a[k] = 24'($random(seed)) & 24'h3FFFFF;
         if (it == 0) a = '0;
         if (it == 1) a[5:3] = {3{24'h3FF6A6}};
         if (it == 2) a[5:3] = {3{24'h000064}};
         if (it == 3) a[5:3] = {3{24'h000100}};
         amp <= a;
         for (int k = 0; k < 3; k++) begin
            vexp[k] = a[3 + k];
            o = 24'($random(seed));
            if (it < 2) o = 24'h0;
            if (it == 2) o = 24'hFE7960;
            if (it == 3) o = 24'h000040;
            wr_ofs(2'(k), o);
         end
         wiring <= (it >= 4 && it[0]) ? 2'h1 : 2'h0;
         // enough sets for a full-scale mean square to decay below the clamp case
         run_sets(64);
         check_all();
      end
      // estimate keeps running while rms stays frozen
      full_power_mode <= 1'b0;
      reduced_power_mode <= 1'b1;
      for (int k = 0; k < 6; k++) a[k] = 24'($random(seed)) & 24'h3FFFFF;
      amp <= a;
      wr_ofs(2'h3, 24'h123456);
      run_sets(40);
      check_all();
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
